// ### tcc_top.sv
// Two-channel capture/compare pair with its counter and AXI4-Lite registers.
// Assumes pins arrive asynchronously; port mux outside uses pin enables.
//
// Decided for this implementation: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ns
module tcc_top
    import tcc_pkg::*;
#(
    parameter int NCH = 2
)(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [1:0]  channel_pin_in,
    output logic [1:0]       channel_pin_out,
    output logic [1:0]       channel_pin_oe,
    output logic [1:0]       channel_event_flag,
    output logic             counter_wrap_flag
);
    // Counter state
    logic [15:0] cnt_q, cnt_d;
    logic [15:0] mod_q, mod_d;
    logic        wrap, wrap_q;

    // Channel state
    tcc_ctrl_s   ctl_q [NCH];
    tcc_ctrl_s   ctl_d [NCH];
    logic [15:0] val_q [NCH];
    logic [15:0] val_d [NCH];
    logic [NCH-1:0] cap_blk_q, cap_blk_d;
    logic [NCH-1:0] cmp_blk_q, cmp_blk_d;
    logic [NCH-1:0] flag_seen_q, flag_seen_d;
    logic        buf_sel_q, buf_sel_d;

    // Bus state
    logic        aw_hold_q, aw_hold_d;
    logic        w_hold_q, w_hold_d;
    logic [7:0]  awa_q, awa_d;
    logic [31:0] wd_q, wd_d;
    logic        bv_q, bv_d;
    logic        bslv_q, bslv_d;
    logic        rv_q, rv_d;
    logic [31:0] rd_q, rd_d;
    logic        rslv_q, rslv_d;
    logic [1:0]  pout_q, pout_d;
    logic [1:0]  poe_q, poe_d;

    // Per-channel derived terms
    logic [NCH-1:0] connected, capture_mode, compare_mode, disabled_ch, cmp_sel;
    logic [NCH-1:0] cap_edge, match, lvl, sync_lvl, rise, fall;

    logic wr_go, rd_go;

    // Decode whether an address is a mapped register
    function automatic logic addr_ok(input logic [7:0] a);
        addr_ok = (a == TCC_OFS_COUNT) || (a == TCC_OFS_MODULO) ||
                  (a == TCC_OFS_CTRL0) || (a == TCC_OFS_CTRL1) ||
                  (a == TCC_OFS_VAL0_HI) || (a == TCC_OFS_VAL0_LO) ||
                  (a == TCC_OFS_VAL1_HI) || (a == TCC_OFS_VAL1_LO);
    endfunction

    assign wrap = (cnt_q == mod_q);

    always_comb begin
        cnt_d = wrap ? TCC_COUNT_RST : cnt_q + 16'h0001;
    end

    // Per-channel pin sync, mode decode and output state
    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_ch
            tcc_sync u_sync (
                .aclk    (aclk),
                .aresetn (aresetn),
                .pin_in  (channel_pin_in[g]),
                .level   (sync_lvl[g]),
                .rise    (rise[g]),
                .fall    (fall[g])
            );
            // odd channel disabled by even buffered bit
            if (g % 2 == 1) begin : g_odd
                assign disabled_ch[g] = ctl_q[g-1].buffered_mode_sel;
            end else begin : g_even
                assign disabled_ch[g] = 1'b0;
            end
            assign connected[g] = (ctl_q[g].edge_level_sel_hi | ctl_q[g].edge_level_sel_lo) & ~disabled_ch[g];
            assign capture_mode[g] = connected[g] & ~ctl_q[g].buffered_mode_sel & ~ctl_q[g].capture_or_compare_sel;
            assign compare_mode[g] = connected[g] & ~capture_mode[g];
            assign cmp_sel[g] = ctl_q[g].buffered_mode_sel | ctl_q[g].capture_or_compare_sel | disabled_ch[g];
            assign cap_edge[g] = capture_mode[g] &
                                 ((ctl_q[g].edge_level_sel_lo & rise[g]) | (ctl_q[g].edge_level_sel_hi & fall[g]));
            tcc_chan_out u_out (
                .aclk            (aclk),
                .aresetn         (aresetn),
                .connected       (connected[g]),
                .compare_mode    (compare_mode[g]),
                .preset_low      (ctl_q[g].capture_or_compare_sel),
                .els             ({ctl_q[g].edge_level_sel_hi, ctl_q[g].edge_level_sel_lo}),
                .toggle_at_wrap  (ctl_q[g].toggle_at_wrap),
                .full_duty_force (ctl_q[g].full_duty_force),
                .match           (match[g]),
                .wrap            (wrap),
                .level           (lvl[g])
            );
        end
    endgenerate

    // buffered compare source alternates per period
    always_comb begin
        buf_sel_d = buf_sel_q;
        if (ctl_q[0].buffered_mode_sel && wrap) begin
            buf_sel_d = ~buf_sel_q;
        end else if (!ctl_q[0].buffered_mode_sel) begin
            buf_sel_d = 1'b0;
        end
    end

    // matches suppressed while high byte pending
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            match[i] = compare_mode[i] && !cmp_blk_q[i] && (cnt_q == val_q[i]);
        end
        if (ctl_q[0].buffered_mode_sel) begin
            match[0] = compare_mode[0] && !cmp_blk_q[buf_sel_q] && (cnt_q == val_q[buf_sel_q]);
        end
    end

    // AXI4-Lite handshake and access decode
    assign wr_go = (aw_hold_q || s_axi_awvalid) && (w_hold_q || s_axi_wvalid) && !bv_q;
    assign rd_go = s_axi_arvalid && !rv_q;

    always_comb begin
        logic [7:0]  wa;
        logic [31:0] wdat;
        wa = aw_hold_q ? awa_q : s_axi_awaddr;
        wdat = w_hold_q ? wd_q : s_axi_wdata;
        aw_hold_d = aw_hold_q;
        w_hold_d  = w_hold_q;
        awa_d = awa_q;
        wd_d  = wd_q;
        bv_d  = bv_q && !s_axi_bready;
        bslv_d = bslv_q;
        rv_d  = rv_q && !s_axi_rready;
        rd_d  = rd_q;
        rslv_d = rslv_q;
        mod_d = mod_q;
        ctl_d = ctl_q;
        val_d = val_q;
        cap_blk_d = cap_blk_q;
        cmp_blk_d = cmp_blk_q;
        flag_seen_d = flag_seen_q;
        if (s_axi_awvalid && !aw_hold_q && !bv_q) begin
            aw_hold_d = 1'b1;
            awa_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_hold_q && !bv_q) begin
            w_hold_d = 1'b1;
            wd_d = s_axi_wdata;
        end
        // Register read with side effects
        if (rd_go) begin
            rv_d = 1'b1;
            rslv_d = !addr_ok(s_axi_araddr);
            rd_d = 32'h0000_0000;
            unique case (s_axi_araddr)
                TCC_OFS_COUNT:  rd_d[15:0] = cnt_q;
                TCC_OFS_MODULO: rd_d[15:0] = mod_q;
                TCC_OFS_CTRL0, TCC_OFS_CTRL1: begin
                    rd_d[7:0] = ctl_q[s_axi_araddr[2]];
                    flag_seen_d[s_axi_araddr[2]] = ctl_q[s_axi_araddr[2]].flag;
                end
                TCC_OFS_VAL0_HI, TCC_OFS_VAL1_HI: begin
                    rd_d[7:0] = val_q[s_axi_araddr[3]][15:8];
                    if (!cmp_sel[s_axi_araddr[3]]) begin
                        cap_blk_d[s_axi_araddr[3]] = 1'b1;
                    end
                end
                TCC_OFS_VAL0_LO, TCC_OFS_VAL1_LO: begin
                    rd_d[7:0] = val_q[s_axi_araddr[3]][7:0];
                    cap_blk_d[s_axi_araddr[3]] = 1'b0;
                end
                default: rd_d = 32'h0000_0000;
            endcase
        end
        // Register write with side effects
        if (wr_go) begin
            aw_hold_d = 1'b0;
            w_hold_d  = 1'b0;
            bv_d = 1'b1;
            bslv_d = !addr_ok(wa);
            if (s_axi_wstrb[0]) begin
                unique case (wa)
                    TCC_OFS_MODULO: mod_d[7:0] = wdat[7:0];
                    TCC_OFS_CTRL0, TCC_OFS_CTRL1: begin
                        // clear only after read-as-set; write 1 ignored
                        ctl_d[wa[2]] = tcc_ctrl_s'(wdat[7:0]);
                        ctl_d[wa[2]].flag = ctl_q[wa[2]].flag &
                                            (wdat[TCC_BIT_FLAG] | ~flag_seen_q[wa[2]]);
                        flag_seen_d[wa[2]] = 1'b0;
                        // Only even channels own a buffered bit
                        if (wa[2]) begin
                            ctl_d[1].buffered_mode_sel = 1'b0;
                        end
                        if (wa[2] && ctl_q[0].buffered_mode_sel) begin
                            ctl_d[1] = ctl_q[1];
                        end
                    end
                    TCC_OFS_VAL0_HI, TCC_OFS_VAL1_HI: begin
                        val_d[wa[3]][15:8] = wdat[7:0];
                        if (cmp_sel[wa[3]]) begin
                            cmp_blk_d[wa[3]] = 1'b1;
                        end
                    end
                    TCC_OFS_VAL0_LO, TCC_OFS_VAL1_LO: begin
                        val_d[wa[3]][7:0] = wdat[7:0];
                        cmp_blk_d[wa[3]] = 1'b0;
                    end
                    default: ;
                endcase
            end
            if (s_axi_wstrb[1] && wa == TCC_OFS_MODULO) begin
                mod_d[15:8] = wdat[15:8];
            end
        end
        // Hardware events; set wins over a clearing write
        for (int i = 0; i < NCH; i++) begin
            if (cap_edge[i] && !cap_blk_q[i]) begin
                val_d[i] = cnt_q;
            end
            if ((cap_edge[i] && !cap_blk_q[i]) || match[i]) begin
                ctl_d[i].flag = 1'b1;
                flag_seen_d[i] = 1'b0;
            end
        end
    end

    // Pin drive: compare-mode channel drives from preset level
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            pout_d[i] = lvl[i];
            poe_d[i]  = compare_mode[i];
        end
    end

    always_ff @(posedge aclk) begin
        val_q <= val_d;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q <= TCC_COUNT_RST;
            mod_q <= TCC_MODULO_RST;
            for (int i = 0; i < NCH; i++) begin
                ctl_q[i] <= '0;
            end
            cap_blk_q <= '0;
            cmp_blk_q <= '0;
            flag_seen_q <= '0;
            buf_sel_q <= 1'b0;
            wrap_q <= 1'b0;
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            awa_q <= 8'h00;
            wd_q <= 32'h0000_0000;
            bv_q <= 1'b0;
            bslv_q <= 1'b0;
            rv_q <= 1'b0;
            rd_q <= 32'h0000_0000;
            rslv_q <= 1'b0;
            pout_q <= 2'b00;
            poe_q <= 2'b00;
        end else begin
            cnt_q <= cnt_d;
            mod_q <= mod_d;
            ctl_q <= ctl_d;
            cap_blk_q <= cap_blk_d;
            cmp_blk_q <= cmp_blk_d;
            flag_seen_q <= flag_seen_d;
            buf_sel_q <= buf_sel_d;
            wrap_q <= wrap;
            aw_hold_q <= aw_hold_d;
            w_hold_q <= w_hold_d;
            awa_q <= awa_d;
            wd_q <= wd_d;
            bv_q <= bv_d;
            bslv_q <= bslv_d;
            rv_q <= rv_d;
            rd_q <= rd_d;
            rslv_q <= rslv_d;
            pout_q <= pout_d;
            poe_q <= poe_d;
        end
    end

    // Outputs straight from flip-flops
    assign s_axi_awready = !aw_hold_q && !bv_q;
    assign s_axi_wready  = !w_hold_q && !bv_q;
    assign s_axi_bvalid  = bv_q;
    assign s_axi_bresp   = bslv_q ? TCC_RESP_SLVERR : TCC_RESP_OKAY;
    assign s_axi_arready = !rv_q;
    assign s_axi_rvalid  = rv_q;
    assign s_axi_rdata   = rd_q;
    assign s_axi_rresp   = rslv_q ? TCC_RESP_SLVERR : TCC_RESP_OKAY;
    assign channel_pin_out = pout_q;
    assign channel_pin_oe  = poe_q;
    assign channel_event_flag = {ctl_q[1].flag, ctl_q[0].flag};
    assign counter_wrap_flag = wrap_q;
endmodule

// ### tcc_pkg.sv
// Constants, register map and carrier types for the timer channel pair block.
// Assumes a 32-bit AXI4-Lite register port and a single 250 MHz bus clock.
//
// What this block does
// - Select bits both zero: channel leaves its pin to port control.
// - Disconnected channel holds preset level: high if low mode bit 0, low if 1.
// - Enabled compare channel drives pin, starting from the preset internal level; capture leaves it undriven.
// - Mode 00 captures: 01 rising, 10 falling, 11 either edge.
// - Mode 01 unbuffered compare: 01 toggles, 10 clears, 11 sets on match.
// - Buffered mode bit set: buffered compare with the same match actions.
// - Toggle-at-wrap toggles compare output on overflow; no effect in capture; resets zero.
// - With toggle-at-wrap, overflow wins over a simultaneous compare match.
// - Toggle-at-wrap plus clear-on-compare plus full-duty force gives 100% duty.
// - Full-duty changes take effect in the PWM period after the write.
// - 100% duty is constant high for polarity 1; polarity 0 has no forced 100% duty.
// - 0% duty is constant low for polarity 1, high for polarity 0.
// - Value register holds capture or compare value; reset value undefined.
// - Capture mode: reading high byte blocks captures until low byte read.
// - Compare mode: writing high byte blocks matches until low byte written.
// - Reset clears both edge/level select bits of every channel.
// - Event flag sets on active capture edge or counter equal to value.
// - Flag clears only by read-as-set then write 0; new event keeps it.
// - Even channel buffered bit disables odd channel and frees its pin.
// - Overflow at modulo value; counter resumes from zero next timer clock.
package tcc_pkg;

    // Register byte offsets, one aligned word each
    localparam logic [7:0] TCC_OFS_COUNT     = 8'h00;
    localparam logic [7:0] TCC_OFS_MODULO    = 8'h04;
    localparam logic [7:0] TCC_OFS_CTRL0     = 8'h08;
    localparam logic [7:0] TCC_OFS_CTRL1     = 8'h0c;
    localparam logic [7:0] TCC_OFS_VAL0_HI   = 8'h10;
    localparam logic [7:0] TCC_OFS_VAL0_LO   = 8'h14;
    localparam logic [7:0] TCC_OFS_VAL1_HI   = 8'h18;
    localparam logic [7:0] TCC_OFS_VAL1_LO   = 8'h1c;

    // Channel control field positions
    localparam int TCC_BIT_FULL_DUTY = 0;
    localparam int TCC_BIT_TOGGLE    = 1;
    localparam int TCC_BIT_ELS_LO    = 2;
    localparam int TCC_BIT_ELS_HI    = 3;
    localparam int TCC_BIT_MODE_LO   = 4;
    localparam int TCC_BIT_MODE_HI   = 5;
    localparam int TCC_BIT_IRQ_EN    = 6;
    localparam int TCC_BIT_FLAG      = 7;

    // Reset values
    localparam logic [15:0] TCC_MODULO_RST = 16'hffff;
    localparam logic [15:0] TCC_COUNT_RST  = 16'h0000;

    // Response codes
    localparam logic [1:0] TCC_RESP_OKAY   = 2'b00;
    localparam logic [1:0] TCC_RESP_SLVERR = 2'b10;

    // Input synchroniser length
    localparam int TCC_SYNC_STAGES = 2;

    // One channel's control fields
    typedef struct packed {
        logic flag;
        logic irq_en;
        logic buffered_mode_sel;
        logic capture_or_compare_sel;
        logic edge_level_sel_hi;
        logic edge_level_sel_lo;
        logic toggle_at_wrap;
        logic full_duty_force;
    } tcc_ctrl_s;

    // Pin drive of one channel
    typedef struct packed {
        logic level;
        logic enable;
    } tcc_pin_s;

endpackage

// ### tcc_sync.sv
// Two-stage synchroniser with edge detect on the synchronised level.
// Assumes the input is asynchronous to aclk.
`timescale 1ns/1ns
module tcc_sync
    import tcc_pkg::*;
(
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic pin_in,
    output logic      level,
    output logic      rise,
    output logic      fall
);
    logic [TCC_SYNC_STAGES:0] sh_q;
    logic [TCC_SYNC_STAGES:0] sh_d;

    // Shift chain; stage 0 is read only by stage 1
    always_comb begin
        sh_d = {sh_q[TCC_SYNC_STAGES-1:0], pin_in};
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sh_q <= '0;
        end else begin
            sh_q <= sh_d;
        end
    end

    assign level = sh_q[TCC_SYNC_STAGES-1];
    assign rise  = sh_q[TCC_SYNC_STAGES-1] & ~sh_q[TCC_SYNC_STAGES];
    assign fall  = ~sh_q[TCC_SYNC_STAGES-1] & sh_q[TCC_SYNC_STAGES];
endmodule

// ### tcc_chan_out.sv
// Output level state of one channel: match actions, wrap toggle, full duty.
// Assumes match and wrap are single-cycle strobes on aclk.
`timescale 1ns/1ns
module tcc_chan_out
    import tcc_pkg::*;
(
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic connected,
    input  wire logic compare_mode,
    input  wire logic preset_low,
    input  wire logic [1:0] els,
    input  wire logic toggle_at_wrap,
    input  wire logic full_duty_force,
    input  wire logic match,
    input  wire logic wrap,
    output logic      level
);
    logic lvl_q;
    logic lvl_d;
    logic force_q;
    logic force_d;

    always_comb begin
        lvl_d   = lvl_q;
        force_d = force_q;
        if (!connected) begin
            lvl_d = ~preset_low;
        end else if (compare_mode) begin
            if (wrap) begin
                force_d = full_duty_force & toggle_at_wrap & (els == 2'b10);
            end
            if (wrap && toggle_at_wrap) begin
                lvl_d = ~lvl_q;
            end else if (match && !force_q) begin
                // match actions; clear gives the low off level
                unique case (els)
                    2'b01:   lvl_d = ~lvl_q;
                    2'b10:   lvl_d = 1'b0;
                    2'b11:   lvl_d = 1'b1;
                    default: lvl_d = lvl_q;
                endcase
            end
            // forced full duty holds high at polarity 1
            if (force_d) begin
                lvl_d = 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lvl_q   <= 1'b1;
            force_q <= 1'b0;
        end else begin
            lvl_q   <= lvl_d;
            force_q <= force_d;
        end
    end

    assign level = lvl_q;
endmodule

// ### tcc_pin_model.sv
// Far-side model of the two channel pins.
// Assumes the bench requests external levels just after a rising aclk edge.
`timescale 1ns/1ns
module tcc_pin_model (
    input  wire logic       aclk,
    input  wire logic [1:0] lvl,
    input  wire logic [1:0] pin_out,
    input  wire logic [1:0] pin_oe,
    output logic      [1:0] pin_in
);
    logic [1:0] ext_q;

    // level held steady
    // External level moves only at a clock edge, so the bench controls settle time
    always_ff @(posedge aclk) begin
        ext_q <= lvl;
    end

    // Wire level: the channel wins while it drives, else the outside source
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_q);
endmodule

// ### tcc_chk.sv
// Port-level checker for the timer channel pair.
// Assumes one aclk domain and synchronous active-low aresetn.
`timescale 1ns/1ns
module tcc_chk (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  channel_pin_oe,
    input wire logic [1:0]  channel_event_flag,
    input wire logic        counter_wrap_flag
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_reset_pins_off: assert property ($rose(aresetn) |-> channel_pin_oe == 2'b00)
        else $error("pin enable set after reset");
    a_reset_flags_low: assert property ($rose(aresetn) |-> channel_event_flag == 2'b00 && !counter_wrap_flag)
        else $error("flag set after reset");
    a_wrap_one_pulse: assert property (counter_wrap_flag |=> (!counter_wrap_flag) [*2])
        else $error("wrap flag not a lone pulse");
    a_flag_clear_write: assert property ($fell(channel_event_flag[0]) || $fell(channel_event_flag[1])
        |-> s_axi_bvalid || $past(s_axi_bvalid)) else $error("flag cleared without a write");
    a_pin_oe_write: assert property ($changed(channel_pin_oe)
        |-> s_axi_bvalid || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2)) else $error("pin enable moved alone");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_read_single: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer repeated");
    a_write_single: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer repeated");

    // Main scenarios reached
    c_flag_set: cover property ($rose(channel_event_flag[0]));
    c_flag_clr: cover property ($fell(channel_event_flag[0]));
    c_wrap: cover property (counter_wrap_flag);
    c_odd_off: cover property ($fell(channel_pin_oe[1]));
endmodule

bind tcc_top tcc_chk tcc_chk_i (.aclk, .aresetn, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
    .s_axi_bvalid, .s_axi_bready, .channel_pin_oe, .channel_event_flag, .counter_wrap_flag);

// ### tcc_top_tb.sv
// Self-checking bench for the timer channel pair.
// Assumes the pin model on the far side and AXI4-Lite register access.
`timescale 1ns/1ns
module tcc_top_tb;
    import tcc_pkg::*;
    logic        aclk = 0, aresetn = 0;
    logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, rv;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0, s_axi_bready = 1, s_axi_rready = 1;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, counter_wrap_flag;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rr, channel_pin_in, channel_pin_out, channel_pin_oe, channel_event_flag;
    logic [1:0]  ext = 0;
    int          errors = 0, checks_done = 0;

    tcc_top tcc_top_i (.*);
    tcc_pin_model tcc_pin_model_i (.aclk(aclk), .lvl(ext), .pin_out(channel_pin_out), .pin_oe(channel_pin_oe),
        .pin_in(channel_pin_in));

    // Bus clock, 4 ns period
    always #2 aclk = ~aclk;

    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            errors++;
            $display("BAD t=%0t seen %h exp %h", $time, s, e);
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge aclk);
    endtask

    // Bus write: address and data offered together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        repeat (40) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                chk(s_axi_bresp, TCC_RESP_OKAY);
                return;
            end
        end
        chk(0, 1);
        stop_test();
    endtask

    // Bus read into rv and rr
    task automatic rd(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        repeat (40) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                rv = s_axi_rdata;
                rr = s_axi_rresp;
                return;
            end
        end
        chk(0, 1);
        stop_test();
    endtask

    // High cycles of channel 0 over n cycles
    task automatic cnt(input int n, output logic [31:0] c);
        c = 0;
        repeat (n) begin
            @(posedge aclk);
            c += channel_pin_out[0];
        end
    endtask

    task automatic t_reset();
        aresetn <= 1'b0;
        wt(5);
        aresetn <= 1'b1;
        wt(1);
        chk(channel_pin_oe, 0);
        chk({channel_event_flag, counter_wrap_flag}, 0);
        rd(TCC_OFS_CTRL0);
        chk(rv, 0);
        rd(TCC_OFS_CTRL1);
        chk(rv, 0);
        rd(TCC_OFS_MODULO);
        chk(rv[15:0], TCC_MODULO_RST);
        rd(8'h20);
        chk(rr, TCC_RESP_SLVERR);
        chk(rv, 32'h0000_0000);
        wr(TCC_OFS_MODULO, 32'h0000_00ff);
        $display("reset test done");
    endtask

    task automatic t_capture();
        logic [15:0] c0, v;
        for (int e = 1; e < 4; e++) begin
            ext <= 2'b00;
            wt(4);
            wr(TCC_OFS_CTRL0, 32'(e << 2));
            rd(TCC_OFS_CTRL0);
            wr(TCC_OFS_CTRL0, 32'(e << 2));
            ext <= 2'b01;
            wt(8);
            chk(channel_event_flag[0], e[0]);
            rd(TCC_OFS_CTRL0);
            wr(TCC_OFS_CTRL0, 32'(e << 2));
            chk(channel_event_flag[0], 0);
            ext <= 2'b00;
            wt(8);
            chk(channel_event_flag[0], e[1]);
        end
        rd(TCC_OFS_COUNT);
        c0 = rv[15:0];
        ext <= 2'b01;
        wt(8);
        rd(TCC_OFS_VAL0_HI);
        v[15:8] = rv[7:0];
        rd(TCC_OFS_VAL0_LO);
        v[7:0] = rv[7:0];
        chk(8'(v[7:0] - c0[7:0]) < 8'd24 && v[15:8] == 8'h00, 1);
        rd(TCC_OFS_VAL0_HI);
        ext <= 2'b00;
        wt(8);
        rd(TCC_OFS_VAL0_LO);
        chk(rv[7:0], v[7:0]);
        ext <= 2'b01;
        wt(8);
        rd(TCC_OFS_VAL0_HI);
        rd(TCC_OFS_VAL0_LO);
        chk(rv[7:0] != v[7:0], 1);
        rd(TCC_OFS_CTRL0);
        wr(TCC_OFS_CTRL0, 32'h0000_000c);
        wr(TCC_OFS_CTRL0, 32'h0000_008c);
        chk(channel_event_flag[0], 0);
        $display("capture test done");
    endtask

    task automatic t_compare();
        logic s;
        wr(TCC_OFS_CTRL0, 32'h0000_0010);
        wt(4);
        chk(channel_pin_oe[0], 0);
        wr(TCC_OFS_VAL0_HI, 32'h0000_0000);
        wr(TCC_OFS_CTRL0, 32'h0000_001c);
        wt(300);
        chk({channel_pin_oe[0], channel_pin_out[0], channel_event_flag[0]}, 3'b100);
        wr(TCC_OFS_VAL0_LO, 32'h0000_0080);
        wt(300);
        chk({channel_pin_out[0], channel_event_flag[0]}, 2'b11);
        rd(TCC_OFS_CTRL0);
        wr(TCC_OFS_CTRL0, 32'h0000_0014);
        wt(4);
        s = channel_pin_out[0];
        wt(256);
        chk(channel_pin_out[0], !s);
        wr(TCC_OFS_CTRL0, 32'h0000_0018);
        wt(300);
        chk(channel_pin_out[0], 0);
        $display("compare test done");
    endtask

    task automatic t_pwm();
        logic [31:0] c;
        wr(TCC_OFS_CTRL0, 32'h0000_001a);
        wr(TCC_OFS_VAL0_HI, 32'h0000_0000);
        wr(TCC_OFS_VAL0_LO, 32'h0000_0040);
        wt(600);
        cnt(256, c);
        chk(c inside {[63:66]}, 1);
        wr(TCC_OFS_CTRL0, 32'h0000_001b);
        wt(600);
        cnt(256, c);
        chk(c, 256);
        wr(TCC_OFS_CTRL0, 32'h0000_001a);
        wt(600);
        cnt(256, c);
        chk(c inside {[63:66]}, 1);
        wr(TCC_OFS_VAL0_LO, 32'h0000_00ff);
        wt(600);
        cnt(512, c);
        chk(c, 256);
        $display("pwm test done");
    endtask

    task automatic t_buffered();
        logic [31:0] c;
        wr(TCC_OFS_CTRL1, 32'h0000_001c);
        wt(4);
        chk(channel_pin_oe[1], 1);
        wr(TCC_OFS_VAL1_HI, 32'h0000_0000);
        wr(TCC_OFS_VAL1_LO, 32'h0000_0040);
        wr(TCC_OFS_VAL0_LO, 32'h0000_0040);
        wr(TCC_OFS_CTRL0, 32'h0000_002a);
        wt(4);
        chk(channel_pin_oe[1], 0);
        wt(600);
        cnt(512, c);
        chk(c inside {[126:132]}, 1);
        wr(TCC_OFS_VAL1_LO, 32'h0000_00c0);
        wt(600);
        cnt(512, c);
        chk(c inside {[252:262]}, 1);
        $display("buffered test done");
    endtask

    // Main sequence, ending with a reset in mid-run
    initial begin
        t_reset();
        t_capture();
        t_compare();
        t_pwm();
        t_buffered();
        t_reset();
        stop_test();
    end
endmodule
